// File: design/aei_pkg.sv
// constants for the asynchronous event information encoder
// assumes one clock domain and host log reads presented as one-cycle pulses
package aei_pkg;
	localparam logic [2:0] TYPE_HEALTH = 3'h1;
	localparam logic [2:0] TYPE_NOTICE = 3'h2;
	localparam int TYPE_LSB = 0;
	localparam int INFO_LSB = 8;
	localparam int LOGID_LSB = 16;
	localparam logic [7:0] HI_RELIABILITY = 8'h00;
	localparam logic [7:0] HI_TEMPERATURE = 8'h01;
	localparam logic [7:0] HI_SPARE = 8'h02;
	localparam logic [7:0] NI_NS_CHANGED = 8'h00;
	localparam logic [7:0] NI_FW_ACTIVATE = 8'h01;
	localparam logic [7:0] NI_TELEMETRY = 8'h02;
	localparam logic [7:0] NI_ACCESS = 8'h03;
	localparam logic [7:0] NI_LATENCY_AGG = 8'h04;
	localparam logic [7:0] NI_BLOCK_STATUS = 8'h05;
	localparam logic [7:0] NI_ENDURANCE_AGG = 8'h06;
	localparam logic [7:0] LOG_NS_CHANGED = 8'h04;
	// log identifiers below are parameters of the top; these are their defaults
	localparam logic [7:0] LOG_HEALTH_DEF = 8'h02;
	localparam logic [7:0] LOG_FW_SLOT_DEF = 8'h03;
	localparam logic [7:0] LOG_TELEMETRY_DEF = 8'h08;
	localparam logic [7:0] LOG_ACCESS_DEF = 8'h0C;
	localparam logic [7:0] LOG_LATENCY_DEF = 8'h0B;
	localparam logic [7:0] LOG_BLOCK_DEF = 8'h0E;
	localparam logic [7:0] LOG_ENDURANCE_DEF = 8'h0F;
	localparam int NUM_EV = 9;
	localparam logic [6:0] FPI_ZERO = 7'h00;
	typedef enum logic [3:0] {
		EV_RELIAB, EV_TEMP, EV_SPARE, EV_NS, EV_FW, EV_TELEM, EV_ACCESS, EV_LATENCY, EV_BLOCK
	} aei_ev_t;
endpackage

// File: design/aei_encoder.sv
// asynchronous event information encoder: latches events, reports one at a time
// assumes the host side holds a request level until an event is shown, and sends one-cycle log-read pulses
`timescale 1ns/1ns
module aei_encoder #(
	parameter logic [7:0] LOG_HEALTH     = aei_pkg::LOG_HEALTH_DEF,
	parameter logic [7:0] LOG_FW_SLOT    = aei_pkg::LOG_FW_SLOT_DEF,
	parameter logic [7:0] LOG_TELEMETRY  = aei_pkg::LOG_TELEMETRY_DEF,
	parameter logic [7:0] LOG_ACCESS     = aei_pkg::LOG_ACCESS_DEF,
	parameter logic [7:0] LOG_LATENCY    = aei_pkg::LOG_LATENCY_DEF,
	parameter logic [7:0] LOG_BLOCK      = aei_pkg::LOG_BLOCK_DEF,
	parameter logic [7:0] LOG_ENDURANCE  = aei_pkg::LOG_ENDURANCE_DEF
) (
	// clock and reset
	input  wire logic        clock_i,
	input  wire logic        srst_i,
	// health sources: one-cycle pulses, then temperature and spare levels with their thresholds
	input  wire logic        media_error_i,
	input  wire logic        internal_error_i,
	input  wire logic        read_only_i,
	input  wire logic        read_only_by_wp_i,
	input  wire logic        backup_fail_i,
	input  wire logic [15:0] temperature_i,
	input  wire logic [15:0] over_temp_thresh_i,
	input  wire logic [15:0] under_temp_thresh_i,
	input  wire logic [7:0]  spare_avail_i,
	input  wire logic [7:0]  spare_thresh_i,
	// notice sources: one-cycle pulses, except format_progress_i, which is a level
	input  wire logic        ns_identify_change_i,
	input  wire logic        ns_list_change_i,
	input  wire logic        ns_util_only_i,
	input  wire logic        ns_group_id_only_i,
	input  wire logic        ns_capacity_by_access_i,
	input  wire logic [6:0]  format_progress_i,
	input  wire logic        fw_activate_start_i,
	input  wire logic        fw_activate_done_i,
	input  wire logic        telemetry_saved_i,
	input  wire logic        access_change_i,
	input  wire logic        access_by_ns_mgmt_i,
	input  wire logic        latency_agg_added_i,
	input  wire logic        block_alert_i,
	input  wire logic        endurance_agg_added_i,
	// host side
	input  wire logic        aer_outstanding_i,
	input  wire logic        log_read_i,
	input  wire logic [7:0]  log_read_id_i,
	input  wire logic        log_read_retain_i,
	// outputs
	output logic             event_valid_o,
	output logic [31:0]      event_dword0_o,
	output logic             processing_paused_flag_o,
	output logic             telemetry_data_avail_o,
	output logic [8:0]       pending_o,
	output logic [8:0]       reported_o
);
	import aei_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	logic [8:0]  raise;
	logic [8:0]  clear;
	logic [8:0]  pend_reg;
	logic [8:0]  rep_reg;
	logic [6:0]  fpi_reg;
	logic        fpi_seen_reg;
	logic        spare_low_reg;
	logic        temp_bad_reg;
	logic        tele_reg;
	logic        fpi_edge;
	logic        temp_bad;
	logic        spare_low;
	logic        ev_valid_reg;
	logic [31:0] dw_reg;
	logic [3:0]  sel;
	logic        sel_ok;

	function automatic logic [31:0] pack_dw(input logic [2:0] t, input logic [7:0] info, input logic [7:0] lid);
		pack_dw = 32'h0000_0000;
		pack_dw[TYPE_LSB +: 3] = t;
		pack_dw[INFO_LSB +: 8] = info;
		pack_dw[LOGID_LSB +: 8] = lid;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// condition detection
	assign temp_bad = (temperature_i >= over_temp_thresh_i) || (temperature_i <= under_temp_thresh_i);
	assign spare_low = spare_avail_i < spare_thresh_i;
	// only the zero/nonzero boundary of the progress indicator matters
	assign fpi_edge = fpi_seen_reg && ((fpi_reg == FPI_ZERO) != (format_progress_i == FPI_ZERO));

	always_comb begin
		raise = 9'h000;
		raise[EV_RELIAB] = media_error_i || internal_error_i || backup_fail_i
			|| (read_only_i && !read_only_by_wp_i);
		raise[EV_TEMP] = temp_bad && !temp_bad_reg;
		raise[EV_SPARE] = spare_low && !spare_low_reg;
		raise[EV_NS] = ((ns_identify_change_i && !ns_util_only_i && !ns_group_id_only_i
			&& !ns_capacity_by_access_i) || ns_list_change_i || fpi_edge);
		raise[EV_FW] = fw_activate_start_i;
		raise[EV_TELEM] = tele_reg;
		raise[EV_ACCESS] = access_change_i && !access_by_ns_mgmt_i;
		raise[EV_LATENCY] = latency_agg_added_i;
		raise[EV_BLOCK] = block_alert_i;
	end

	always_comb begin
		clear = 9'h000;
		if (log_read_i) begin
			clear[EV_RELIAB] = log_read_id_i == LOG_HEALTH;
			clear[EV_TEMP] = log_read_id_i == LOG_HEALTH;
			clear[EV_SPARE] = log_read_id_i == LOG_HEALTH;
			clear[EV_NS] = (log_read_id_i == LOG_NS_CHANGED) && !log_read_retain_i;
			clear[EV_FW] = log_read_id_i == LOG_FW_SLOT;
			clear[EV_TELEM] = (log_read_id_i == LOG_TELEMETRY) && !log_read_retain_i;
			clear[EV_ACCESS] = (log_read_id_i == LOG_ACCESS) && !log_read_retain_i;
			clear[EV_LATENCY] = (log_read_id_i == LOG_LATENCY) && !log_read_retain_i;
			clear[EV_BLOCK] = (log_read_id_i == LOG_BLOCK) && !log_read_retain_i;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// history of levels used for edges
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			fpi_reg <= 7'h00;
			fpi_seen_reg <= 1'b0;
			temp_bad_reg <= 1'b0;
			spare_low_reg <= 1'b0;
		end else begin
			fpi_reg <= format_progress_i;
			fpi_seen_reg <= 1'b1;
			temp_bad_reg <= temp_bad;
			spare_low_reg <= spare_low;
		end
	end

	// telemetry is marked available one cycle before its notice is pending
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			tele_reg <= 1'b0;
			telemetry_data_avail_o <= 1'b0;
		end else begin
			tele_reg <= telemetry_saved_i;
			if (telemetry_saved_i) begin
				telemetry_data_avail_o <= 1'b1;
			end else if (clear[EV_TELEM]) begin
				telemetry_data_avail_o <= 1'b0;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			processing_paused_flag_o <= 1'b0;
		end else if (fw_activate_start_i) begin
			processing_paused_flag_o <= 1'b1;
		end else if (fw_activate_done_i) begin
			processing_paused_flag_o <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pending and reported: a new raise beats a clear in the same cycle
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			pend_reg <= 9'h000;
		end else begin
			pend_reg <= (pend_reg & ~clear) | raise;
		end
	end

	// endurance aggregate event is kept apart: it is not in the nine-bit set
	logic endur_pend_reg;
	logic endur_rep_reg;
	logic endur_clear;
	assign endur_clear = log_read_i && (log_read_id_i == LOG_ENDURANCE) && !log_read_retain_i;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			endur_pend_reg <= 1'b0;
		end else begin
			endur_pend_reg <= (endur_pend_reg && !endur_clear) || endurance_agg_added_i;
		end
	end

	// lowest pending, unreported event wins; selection is combinational
	always_comb begin
		sel = 4'h0;
		sel_ok = 1'b0;
		for (int i = NUM_EV - 1; i >= 0; i--) begin
			if (pend_reg[i] && !rep_reg[i]) begin
				sel = i[3:0];
				sel_ok = 1'b1;
			end
		end
	end

	logic take;
	logic take_endur;
	assign take = aer_outstanding_i && !ev_valid_reg && sel_ok;
	assign take_endur = aer_outstanding_i && !ev_valid_reg && !sel_ok && endur_pend_reg && !endur_rep_reg;

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			rep_reg <= 9'h000;
		end else begin
			for (int i = 0; i < NUM_EV; i++) begin
				if (clear[i] && !raise[i]) begin
					rep_reg[i] <= 1'b0;
				end else if (take && sel == i[3:0]) begin
					rep_reg[i] <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			endur_rep_reg <= 1'b0;
		end else if (endur_clear && !endurance_agg_added_i) begin
			endur_rep_reg <= 1'b0;
		end else if (take_endur) begin
			endur_rep_reg <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// completion dword; only codes 00h..06h are ever produced
	always_ff @(posedge clock_i) begin
		if (srst_i) begin
			ev_valid_reg <= 1'b0;
			dw_reg <= 32'h0000_0000;
		end else begin
			ev_valid_reg <= take || take_endur;
			if (take_endur) begin
				dw_reg <= pack_dw(TYPE_NOTICE, NI_ENDURANCE_AGG, LOG_ENDURANCE);
			end else if (take) begin
				case (sel)
					EV_RELIAB:  dw_reg <= pack_dw(TYPE_HEALTH, HI_RELIABILITY, LOG_HEALTH);
					EV_TEMP:    dw_reg <= pack_dw(TYPE_HEALTH, HI_TEMPERATURE, LOG_HEALTH);
					EV_SPARE:   dw_reg <= pack_dw(TYPE_HEALTH, HI_SPARE, LOG_HEALTH);
					EV_NS:      dw_reg <= pack_dw(TYPE_NOTICE, NI_NS_CHANGED, LOG_NS_CHANGED);
					EV_FW:      dw_reg <= pack_dw(TYPE_NOTICE, NI_FW_ACTIVATE, LOG_FW_SLOT);
					EV_TELEM:   dw_reg <= pack_dw(TYPE_NOTICE, NI_TELEMETRY, LOG_TELEMETRY);
					EV_ACCESS:  dw_reg <= pack_dw(TYPE_NOTICE, NI_ACCESS, LOG_ACCESS);
					EV_LATENCY: dw_reg <= pack_dw(TYPE_NOTICE, NI_LATENCY_AGG, LOG_LATENCY);
					default:    dw_reg <= pack_dw(TYPE_NOTICE, NI_BLOCK_STATUS, LOG_BLOCK);
				endcase
			end
		end
	end

	assign event_valid_o = ev_valid_reg;
	assign event_dword0_o = dw_reg;
	assign pending_o = pend_reg;
	assign reported_o = rep_reg;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_read_only_wp;
		read_only_i && read_only_by_wp_i && !media_error_i && !internal_error_i && !backup_fail_i;
	endsequence

	sequence s_take_block;
		take && sel == EV_BLOCK;
	endsequence

	reliab_wp_a: assert property (@(posedge clock_i) disable iff (srst_i)
		(s_read_only_wp and !pend_reg[EV_RELIAB]) |=> !pend_reg[EV_RELIAB])
		else $error("write protect raised reliability event");
	temp_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		temp_bad && !temp_bad_reg |=> pend_reg[EV_TEMP])
		else $error("temperature crossing not pending");
	spare_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		spare_low && !spare_low_reg |=> pend_reg[EV_SPARE])
		else $error("spare low not pending");
	ns_suppress_a: assert property (@(posedge clock_i) disable iff (srst_i)
		ns_identify_change_i && ns_util_only_i && !ns_list_change_i && !fpi_edge && !pend_reg[EV_NS]
		|=> !pend_reg[EV_NS])
		else $error("utilization change raised notice");
	ns_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		log_read_i && log_read_id_i == LOG_NS_CHANGED && !log_read_retain_i && !raise[EV_NS]
		|=> !pend_reg[EV_NS])
		else $error("namespace event not cleared");
	fw_pause_a: assert property (@(posedge clock_i) disable iff (srst_i)
		fw_activate_start_i |=> processing_paused_flag_o && pend_reg[EV_FW])
		else $error("firmware activation not flagged");
	tele_order_a: assert property (@(posedge clock_i) disable iff (srst_i)
		$rose(pend_reg[EV_TELEM]) |-> telemetry_data_avail_o && $past(telemetry_data_avail_o))
		else $error("telemetry notice before data available");
	access_mgmt_a: assert property (@(posedge clock_i) disable iff (srst_i)
		access_change_i && access_by_ns_mgmt_i && !pend_reg[EV_ACCESS] |=> !pend_reg[EV_ACCESS])
		else $error("namespace management raised access notice");
	code_range_a: assert property (@(posedge clock_i) disable iff (srst_i)
		event_valid_o |-> event_dword0_o[15:8] <= NI_ENDURANCE_AGG && event_dword0_o[31:24] == 8'h00)
		else $error("reserved code emitted");
	block_dw_a: assert property (@(posedge clock_i) disable iff (srst_i)
		s_take_block |=> event_valid_o && event_dword0_o == {8'h00, LOG_BLOCK, NI_BLOCK_STATUS, 8'h02})
		else $error("block alert dword wrong");
	no_repeat_a: assert property (@(posedge clock_i) disable iff (srst_i)
		take |-> !rep_reg[sel])
		else $error("event reported twice");

	sequence s_fw_read;
		log_read_i && log_read_id_i == LOG_FW_SLOT && !fw_activate_start_i;
	endsequence

	// saved state is visible a cycle before the notice is pending
	sequence s_tele_raise;
		telemetry_saved_i ##1 telemetry_data_avail_o;
	endsequence

	reliab_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		media_error_i || internal_error_i || backup_fail_i |=> pend_reg[EV_RELIAB])
		else $error("reliability cause not pending");
	ns_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		ns_list_change_i |=> pend_reg[EV_NS])
		else $error("namespace list change not pending");
	ns_retain_a: assert property (@(posedge clock_i) disable iff (srst_i)
		log_read_i && log_read_retain_i && pend_reg[EV_NS] |=> pend_reg[EV_NS])
		else $error("retained read cleared namespace event");
	fpi_steady_a: assert property (@(posedge clock_i) disable iff (srst_i)
		fpi_seen_reg && fpi_reg != FPI_ZERO && format_progress_i != FPI_ZERO && !ns_identify_change_i
		&& !ns_list_change_i && !pend_reg[EV_NS] |=> !pend_reg[EV_NS])
		else $error("progress change inside nonzero range raised notice");
	fw_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		s_fw_read |=> !pend_reg[EV_FW] && !rep_reg[EV_FW])
		else $error("firmware event not cleared");
	tele_pend_a: assert property (@(posedge clock_i) disable iff (srst_i)
		s_tele_raise |=> pend_reg[EV_TELEM])
		else $error("telemetry notice not pending");
	tele_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		log_read_i && log_read_id_i == LOG_TELEMETRY && !log_read_retain_i && !tele_reg
		|=> !pend_reg[EV_TELEM])
		else $error("telemetry event not cleared");
	access_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		access_change_i && !access_by_ns_mgmt_i |=> pend_reg[EV_ACCESS])
		else $error("access change not pending");
	access_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		log_read_i && log_read_id_i == LOG_ACCESS && !log_read_retain_i && !raise[EV_ACCESS]
		|=> !pend_reg[EV_ACCESS])
		else $error("access event not cleared");
	latency_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		latency_agg_added_i |=> pend_reg[EV_LATENCY])
		else $error("latency aggregate not pending");
	block_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		block_alert_i |=> pend_reg[EV_BLOCK])
		else $error("block alert not pending");
	block_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		log_read_i && log_read_id_i == LOG_BLOCK && !log_read_retain_i && !block_alert_i
		|=> !pend_reg[EV_BLOCK] && !rep_reg[EV_BLOCK])
		else $error("block alert not cleared");
	endur_raise_a: assert property (@(posedge clock_i) disable iff (srst_i)
		endurance_agg_added_i |=> endur_pend_reg)
		else $error("endurance aggregate not pending");
	endur_clear_a: assert property (@(posedge clock_i) disable iff (srst_i)
		endur_clear && !endurance_agg_added_i |=> !endur_pend_reg && !endur_rep_reg)
		else $error("endurance event not cleared");
	type_field_a: assert property (@(posedge clock_i) disable iff (srst_i)
		event_valid_o |-> event_dword0_o[7:0] == {5'h00, TYPE_HEALTH} || event_dword0_o[7:0] == {5'h00, TYPE_NOTICE})
		else $error("event type field wrong");
endmodule

// File: test/aei_host_model.sv
// host software model: keeps one event request outstanding on demand and issues log reads
// assumes one clock; every output changes at the falling edge only
`timescale 1ns/1ns
module aei_host_model (
	// clock
	input  wire logic        clock_i,
	// from the encoder
	input  wire logic        event_valid_i,
	input  wire logic [31:0] event_dword0_i,
	// to the encoder
	output logic             aer_outstanding_o,
	output logic             log_read_o,
	output logic [7:0]       log_read_id_o,
	output logic             log_read_retain_o
);
	initial begin
		aer_outstanding_o = 1'b0;
		log_read_o        = 1'b0;
		log_read_id_o     = 8'hFF;
		log_read_retain_o = 1'b1;
	end
	////////////////////////////////////////////////////////////////////////////////
	// request held until an event is seen at a falling edge or lim cycles pass; dropped at that edge
	task automatic take(input int lim, output logic [31:0] dw, output logic got);
		got = 1'b0;
		dw  = 32'h0;
		@(negedge clock_i);
		aer_outstanding_o = 1'b1;
		repeat (lim) begin
			@(negedge clock_i);
			if (event_valid_i === 1'b1) begin
				got = 1'b1;
				dw  = event_dword0_i;
				break;
			end
		end
		aer_outstanding_o = 1'b0;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// one-cycle read; id and retain show their inverse once released, not a stale copy
	task automatic read_log(input logic [7:0] id, input logic ret);
		@(negedge clock_i);
		log_read_o        = 1'b1;
		log_read_id_o     = id;
		log_read_retain_o = ret;
		@(negedge clock_i);
		log_read_o        = 1'b0;
		log_read_id_o     = ~id;
		log_read_retain_o = ~ret;
	endtask
endmodule

// File: test/tb.sv
// self-checking bench for the event information encoder
// assumes the host model answers requests; pulse sources are driven one cycle at a time, temperature, spare and progress levels are held
`timescale 1ns/1ns
module tb;
	import aei_pkg::*;
	localparam logic [23:0] H_REL = {LOG_HEALTH_DEF, HI_RELIABILITY, 5'h00, TYPE_HEALTH};
	localparam logic [23:0] H_TMP = {LOG_HEALTH_DEF, HI_TEMPERATURE, 5'h00, TYPE_HEALTH};
	localparam logic [23:0] H_SPR = {LOG_HEALTH_DEF, HI_SPARE, 5'h00, TYPE_HEALTH};
	localparam logic [23:0] N_NS  = {LOG_NS_CHANGED, NI_NS_CHANGED, 5'h00, TYPE_NOTICE};
	// expected fields per pulse index, same order as the pls bits below
	localparam logic [23:0] EXP_TAB [12] = '{H_REL, H_REL, H_REL, H_REL, N_NS, N_NS,
		{LOG_FW_SLOT_DEF, NI_FW_ACTIVATE, 5'h00, TYPE_NOTICE},
		{LOG_TELEMETRY_DEF, NI_TELEMETRY, 5'h00, TYPE_NOTICE},
		{LOG_ACCESS_DEF, NI_ACCESS, 5'h00, TYPE_NOTICE},
		{LOG_LATENCY_DEF, NI_LATENCY_AGG, 5'h00, TYPE_NOTICE},
		{LOG_BLOCK_DEF, NI_BLOCK_STATUS, 5'h00, TYPE_NOTICE},
		{LOG_ENDURANCE_DEF, NI_ENDURANCE_AGG, 5'h00, TYPE_NOTICE}};
	logic        clock_i;
	logic        srst_i;
	logic [11:0] pls;
	logic [4:0]  qual;
	logic        fw_done;
	logic [15:0] temperature;
	logic [7:0]  spare_avail;
	logic [6:0]  fprog;
	logic        aer;
	logic        lrd;
	logic [7:0]  lrd_id;
	logic        lrd_ret;
	logic        event_valid_o;
	logic [31:0] event_dword0_o;
	logic        paused;
	logic        tel_avail;
	logic [8:0]  pending_o;
	logic [8:0]  reported_o;
	logic [31:0] dw;
	logic        got;
	int          n_mismatch = 0;
	int          compares = 0;
	int          cyc = 0;
	////////////////////////////////////////////////////////////////////////////////
	aei_encoder uut (
		.clock_i(clock_i), .srst_i(srst_i),
		.media_error_i(pls[0]), .internal_error_i(pls[1]), .backup_fail_i(pls[2]),
		.read_only_i(pls[3]), .read_only_by_wp_i(qual[0]),
		.temperature_i(temperature), .over_temp_thresh_i(16'h0064), .under_temp_thresh_i(16'h000A),
		.spare_avail_i(spare_avail), .spare_thresh_i(8'h0A),
		.ns_identify_change_i(pls[4]), .ns_list_change_i(pls[5]), .ns_util_only_i(qual[1]),
		.ns_group_id_only_i(qual[2]), .ns_capacity_by_access_i(qual[3]), .format_progress_i(fprog),
		.fw_activate_start_i(pls[6]), .fw_activate_done_i(fw_done), .telemetry_saved_i(pls[7]),
		.access_change_i(pls[8]), .access_by_ns_mgmt_i(qual[4]), .latency_agg_added_i(pls[9]),
		.block_alert_i(pls[10]), .endurance_agg_added_i(pls[11]),
		.aer_outstanding_i(aer), .log_read_i(lrd), .log_read_id_i(lrd_id), .log_read_retain_i(lrd_ret),
		.event_valid_o(event_valid_o), .event_dword0_o(event_dword0_o),
		.processing_paused_flag_o(paused), .telemetry_data_avail_o(tel_avail),
		.pending_o(pending_o), .reported_o(reported_o));
	aei_host_model host (
		.clock_i(clock_i), .event_valid_i(event_valid_o), .event_dword0_i(event_dword0_o),
		.aer_outstanding_o(aer), .log_read_o(lrd), .log_read_id_o(lrd_id), .log_read_retain_o(lrd_ret));
	////////////////////////////////////////////////////////////////////////////////
	always #5 clock_i = ~clock_i;
	// the whole run needs about 250 cycles
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			n_mismatch++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		if (n_mismatch == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic pulse(input int idx);
		@(negedge clock_i);
		pls[idx] = 1'b1;
		@(negedge clock_i);
		pls[idx] = 1'b0;
	endtask
	task automatic fire(input int idx, input logic [23:0] ex);
		if (idx >= 0) pulse(idx);
		host.take(10, dw, got);
		check("reported", {31'h0, got}, 32'h1);
		check("dword0", dw, {8'h00, ex});
	endtask
	task automatic clr(input logic [7:0] lid, input logic ret, input logic [8:0] ep);
		host.read_log(lid, ret);
		repeat (2) @(negedge clock_i);
		check("pending reported", {14'h0, reported_o, pending_o}, {14'h0, ep, ep});
	endtask
	// a suppressed cause must leave nothing pending and nothing reported
	task automatic quiet(input int idx, input int qi);
		@(negedge clock_i);
		if (qi >= 0) qual[qi] = 1'b1;
		if (idx >= 0) pulse(idx);
		host.take(6, dw, got);
		qual = '0;
		check("suppressed", {31'h0, got}, 32'h0);
		check("pending", {23'h0, pending_o}, 32'h0);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		clock_i = 1'b0;
		srst_i = 1'b1;
		pls = '0;
		qual = '0;
		fw_done = 1'b0;
		temperature = 16'h0032;
		spare_avail = 8'h32;
		fprog = 7'h00;
		repeat (3) @(negedge clock_i);
		check("reset outs", {event_valid_o, paused, tel_avail, 11'h0, reported_o, pending_o}, 32'h0);
		srst_i = 1'b0;
		fire(10, EXP_TAB[10]);
		host.take(6, dw, got);
		check("no repeat", {31'h0, got}, 32'h0);
		clr(LOG_BLOCK_DEF, 1'b1, 9'h100);
		clr(LOG_BLOCK_DEF, 1'b0, 9'h000);
		for (int i = 0; i < 12; i++) begin
			if (i == 10) continue;
			fire(i, EXP_TAB[i]);
			if (i == 6) check("paused", {31'h0, paused}, 32'h1);
			if (i == 7) check("telemetry avail", {31'h0, tel_avail}, 32'h1);
			clr(EXP_TAB[i][23:16], 1'b0, 9'h000);
		end
		// endurance state is not on the pending port: a retained read must keep it reported
		fire(11, EXP_TAB[11]);
		clr(LOG_ENDURANCE_DEF, 1'b1, 9'h000);
		quiet(11, -1);
		clr(LOG_ENDURANCE_DEF, 1'b0, 9'h000);
		fire(11, EXP_TAB[11]);
		clr(LOG_ENDURANCE_DEF, 1'b0, 9'h000);
		@(negedge clock_i);
		fw_done = 1'b1;
		@(negedge clock_i);
		fw_done = 1'b0;
		@(negedge clock_i);
		check("paused", {31'h0, paused}, 32'h0);
		quiet(3, 0);
		for (int q = 1; q < 4; q++) quiet(4, q);
		quiet(8, 4);
		// both thresholds hit exactly, since equality must already count
		for (int k = 0; k < 2; k++) begin
			@(negedge clock_i);
			temperature = k ? 16'h000A : 16'h0064;
			fire(-1, H_TMP);
			clr(LOG_HEALTH_DEF, 1'b0, 9'h000);
			@(negedge clock_i);
			temperature = 16'h0032;
		end
		@(negedge clock_i);
		spare_avail = 8'h0A;
		quiet(-1, -1);
		@(negedge clock_i);
		spare_avail = 8'h09;
		fire(-1, H_SPR);
		clr(LOG_HEALTH_DEF, 1'b0, 9'h000);
		@(negedge clock_i);
		fprog = 7'h05;
		fire(-1, N_NS);
		clr(LOG_NS_CHANGED, 1'b0, 9'h000);
		@(negedge clock_i);
		fprog = 7'h03;
		quiet(-1, -1);
		@(negedge clock_i);
		fprog = 7'h00;
		fire(-1, N_NS);
		clr(LOG_NS_CHANGED, 1'b0, 9'h000);
		give_verdict();
	end
endmodule
